// ===== light_sensor_result_status_regs.sv
// Result, mailbox, power state and key registers of the light sensor, with a link-clock byte port
//
// Summary of operation
// - Visible result bits 15 to 8 read at offset 0x23.
// - Infrared result low byte at 0x24, high byte at 0x25.
// - Auxiliary or UV result low byte at 0x2C, high byte at 0x2D.
// - Offset 0x2E is the mailbox from sequencer to host.
// - Offset 0x30 read-only: bit2 awake, bit1 waiting, bit0 lowest power, rest zero.
// - Writable 32-bit key at 0x3B (most significant) to 0x3E (least significant).
// - Every register of the group reads zero after reset.
// - Visible result bits 7 to 0 read at offset 0x22.
// - Interrupt output active from the cycle after any status bit and its enable are both set.
// - With the UV channel on, its result lands in the auxiliary result word.
`timescale 1ns/1ns
module light_sensor_result_status_regs #(
	parameter int IRQ_BITS = 8                 // Width of interrupt status and enable
) (
	input  wire logic                i_mclk,              // Core clock, 250 MHz
	input  wire logic                i_srst,              // Core synchronous reset, active high
	// Sequencer side, core clock
	input  wire logic                i_meas_done,         // Measurement finished, one-cycle pulse
	input  wire logic                i_vis_valid,         // Visible word valid with i_meas_done
	input  wire logic [15:0]         i_visible_word,      // Visible conversion result
	input  wire logic                i_ir_valid,          // Infrared word valid with i_meas_done
	input  wire logic [15:0]         i_infrared_word,     // Infrared conversion result
	input  wire logic                i_aux_valid,         // Auxiliary word valid with i_meas_done
	input  wire logic [15:0]         i_aux_word,          // Auxiliary conversion result
	input  wire logic                i_ultraviolet_channel_on, // UV channel enabled
	input  wire logic [15:0]         i_ultraviolet_word,  // UV index result
	input  wire logic                i_mailbox_we,        // Sequencer writes the mailbox, pulse
	input  wire logic [7:0]          i_mailbox_data,      // Parameter value for the host
	input  wire logic                i_awake,             // Device awake
	input  wire logic                i_wait_meas,         // Low-power wait for measurement
	input  wire logic                i_lowest_power,      // Lowest power state
	input  wire logic [IRQ_BITS-1:0] i_irq_status,        // Interrupt status bits
	input  wire logic [IRQ_BITS-1:0] i_irq_enable,        // Interrupt enable bits
	output logic                     o_int,               // Interrupt output, active high
	output logic [31:0]              o_reserved_key_word, // Key field as held
	output logic [7:0]               o_mailbox,           // Mailbox as held
	// Host register port, link clock
	input  wire logic                i_link_clk,          // Link clock
	input  wire logic                i_link_srst,         // Link synchronous reset, active high
	input  wire logic                i_link_req,          // Access request, one-cycle pulse
	input  wire logic                i_link_we,           // 1 write, 0 read
	input  wire logic [7:0]          i_link_addr,         // Register offset
	input  wire logic [7:0]          i_link_wdata,        // Write byte
	output logic                     o_link_busy,         // Access in flight, requests ignored
	output logic                     o_link_ack,          // Access done, one-cycle pulse
	output logic [7:0]               o_link_rdata         // Read byte, valid from o_link_ack
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [15:0] visible_result_word;
	logic [15:0] infrared_result_word;
	logic [15:0] aux_uv_result_word;
	logic [7:0]  sequencer_to_host_mailbox;
	logic [7:0]  power_state_flags;
	logic [31:0] reserved_key_word;

	// Link domain request holding
	logic        link_tgl;
	logic        link_we_hold;
	logic [7:0]  link_addr_hold;
	logic [7:0]  link_wdata_hold;
	logic [light_sensor_result_status_pkg::SYNC_STAGES-1:0] link_ack_sync;
	logic        link_ack_seen;

	// Core domain side of the handshake
	logic [light_sensor_result_status_pkg::SYNC_STAGES-1:0] core_req_sync;
	logic        core_req_seen;
	logic        core_tgl;
	logic [7:0]  core_rdata;
	logic        core_access;
	logic        host_wr;

	// Power state pins come from analog control outside this clock
	logic [2:0]  pwr_pins;
	logic [light_sensor_result_status_pkg::SYNC_STAGES-1:0] pwr_chain [3];
	logic [2:0]  pwr_sync;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [7:0] addr);
		unique case (addr)
			light_sensor_result_status_pkg::VISIBLE_RESULT_LOW_OFS:   read_byte = visible_result_word[7:0];
			light_sensor_result_status_pkg::VISIBLE_RESULT_HIGH_OFS:  read_byte = visible_result_word[15:8];
			light_sensor_result_status_pkg::INFRARED_RESULT_LOW_OFS:  read_byte = infrared_result_word[7:0];
			light_sensor_result_status_pkg::INFRARED_RESULT_HIGH_OFS: read_byte = infrared_result_word[15:8];
			light_sensor_result_status_pkg::AUX_UV_RESULT_LOW_OFS:    read_byte = aux_uv_result_word[7:0];
			light_sensor_result_status_pkg::AUX_UV_RESULT_HIGH_OFS:   read_byte = aux_uv_result_word[15:8];
			light_sensor_result_status_pkg::MAILBOX_OFS:              read_byte = sequencer_to_host_mailbox;
			light_sensor_result_status_pkg::POWER_STATE_FLAGS_OFS:    read_byte = power_state_flags;
			light_sensor_result_status_pkg::KEY_BYTE3_OFS:            read_byte = reserved_key_word[31:24];
			light_sensor_result_status_pkg::KEY_BYTE2_OFS:            read_byte = reserved_key_word[23:16];
			light_sensor_result_status_pkg::KEY_BYTE1_OFS:            read_byte = reserved_key_word[15:8];
			light_sensor_result_status_pkg::KEY_BYTE0_OFS:            read_byte = reserved_key_word[7:0];
			default:                                                  read_byte = light_sensor_result_status_pkg::UNMAPPED_READ;
		endcase
	endfunction : read_byte

	// Host write aimed at one offset, in the cycle the core carries it out
	function automatic logic host_hits(input logic [7:0] ofs);
		host_hits = host_wr && (link_addr_hold == ofs);
	endfunction : host_hits

	// ----------------------------------------------------------------
	// Link domain: request capture and answer
	// ----------------------------------------------------------------
	// Fields are frozen while busy so the core samples them stable after the toggle
	always_ff @(posedge i_link_clk) begin
		if (i_link_srst) begin
			link_tgl        <= 1'b0;
			link_we_hold    <= 1'b0;
			link_addr_hold  <= light_sensor_result_status_pkg::BYTE_RST;
			link_wdata_hold <= light_sensor_result_status_pkg::BYTE_RST;
		end else if (i_link_req && !o_link_busy) begin
			link_tgl        <= ~link_tgl;
			link_we_hold    <= i_link_we;
			link_addr_hold  <= i_link_addr;
			link_wdata_hold <= i_link_wdata;
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (i_link_srst) begin
			link_ack_sync <= '0;
			link_ack_seen <= 1'b0;
		end else begin
			link_ack_sync <= {link_ack_sync[0], core_tgl};
			link_ack_seen <= link_ack_sync[1];
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (i_link_srst) begin
			o_link_busy <= 1'b0;
		end else if (i_link_req && !o_link_busy) begin
			o_link_busy <= 1'b1;
		end else if (link_ack_sync[1] != link_ack_seen) begin
			o_link_busy <= 1'b0;
		end
	end

	// Read data is held stable in the core until the next request, so it is safe to take here
	always_ff @(posedge i_link_clk) begin
		if (i_link_srst) begin
			o_link_ack   <= 1'b0;
			o_link_rdata <= light_sensor_result_status_pkg::BYTE_RST;
		end else begin
			o_link_ack <= (link_ack_sync[1] != link_ack_seen);
			if (link_ack_sync[1] != link_ack_seen) begin
				o_link_rdata <= core_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Core domain: request detection and answer
	// ----------------------------------------------------------------
	// Only the two toggles cross through flops; the held fields and core_rdata
	// are read once a toggle has settled, so no word crosses while it moves
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			core_req_sync <= '0;
			core_req_seen <= 1'b0;
		end else begin
			core_req_sync <= {core_req_sync[0], link_tgl};
			core_req_seen <= core_req_sync[1];
		end
	end

	assign core_access = (core_req_sync[1] != core_req_seen);
	assign host_wr     = core_access && link_we_hold;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			core_tgl   <= 1'b0;
			core_rdata <= light_sensor_result_status_pkg::BYTE_RST;
		end else if (core_access) begin
			core_tgl   <= ~core_tgl;
			core_rdata <= link_we_hold ? light_sensor_result_status_pkg::BYTE_RST : read_byte(link_addr_hold);
		end
	end

	// ----------------------------------------------------------------
	// Result words
	// ----------------------------------------------------------------
	// A measurement end beats a host write in the same cycle; fresh data must not be lost.
	// The host can only replace one byte of a word per access.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			visible_result_word <= light_sensor_result_status_pkg::RESULT_WORD_RST;
		end else if (i_meas_done && i_vis_valid) begin
			visible_result_word <= i_visible_word;
		end else if (host_hits(light_sensor_result_status_pkg::VISIBLE_RESULT_LOW_OFS)) begin
			visible_result_word[7:0] <= link_wdata_hold;
		end else if (host_hits(light_sensor_result_status_pkg::VISIBLE_RESULT_HIGH_OFS)) begin
			visible_result_word[15:8] <= link_wdata_hold;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			infrared_result_word <= light_sensor_result_status_pkg::RESULT_WORD_RST;
		end else if (i_meas_done && i_ir_valid) begin
			infrared_result_word <= i_infrared_word;
		end else if (host_hits(light_sensor_result_status_pkg::INFRARED_RESULT_LOW_OFS)) begin
			infrared_result_word[7:0] <= link_wdata_hold;
		end else if (host_hits(light_sensor_result_status_pkg::INFRARED_RESULT_HIGH_OFS)) begin
			infrared_result_word[15:8] <= link_wdata_hold;
		end
	end

	// The UV index and the auxiliary input share one word; with UV on, UV takes it
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			aux_uv_result_word <= light_sensor_result_status_pkg::RESULT_WORD_RST;
		end else if (i_meas_done && i_aux_valid) begin
			aux_uv_result_word <= i_ultraviolet_channel_on ? i_ultraviolet_word : i_aux_word;
		end else if (host_hits(light_sensor_result_status_pkg::AUX_UV_RESULT_LOW_OFS)) begin
			aux_uv_result_word[7:0] <= link_wdata_hold;
		end else if (host_hits(light_sensor_result_status_pkg::AUX_UV_RESULT_HIGH_OFS)) begin
			aux_uv_result_word[15:8] <= link_wdata_hold;
		end
	end

	// ----------------------------------------------------------------
	// Mailbox and key
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			sequencer_to_host_mailbox <= light_sensor_result_status_pkg::BYTE_RST;
		end else if (i_mailbox_we) begin
			sequencer_to_host_mailbox <= i_mailbox_data;
		end else if (host_hits(light_sensor_result_status_pkg::MAILBOX_OFS)) begin
			sequencer_to_host_mailbox <= link_wdata_hold;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			reserved_key_word <= light_sensor_result_status_pkg::KEY_WORD_RST;
		end else if (host_wr) begin
			unique case (link_addr_hold)
				light_sensor_result_status_pkg::KEY_BYTE3_OFS: reserved_key_word[31:24] <= link_wdata_hold;
				light_sensor_result_status_pkg::KEY_BYTE2_OFS: reserved_key_word[23:16] <= link_wdata_hold;
				light_sensor_result_status_pkg::KEY_BYTE1_OFS: reserved_key_word[15:8]  <= link_wdata_hold;
				light_sensor_result_status_pkg::KEY_BYTE0_OFS: reserved_key_word[7:0]   <= link_wdata_hold;
				default: ;
			endcase
		end
	end

	assign o_reserved_key_word = reserved_key_word;
	assign o_mailbox           = sequencer_to_host_mailbox;

	// ----------------------------------------------------------------
	// Power state flags
	// ----------------------------------------------------------------
	assign pwr_pins = {i_awake, i_wait_meas, i_lowest_power};

	// Each pin gets its own chain; only the last stage is read
	for (genvar g = 0; g < 3; g++) begin : g_pwr_sync
		always_ff @(posedge i_mclk) begin
			if (i_srst) begin
				pwr_chain[g] <= '0;
			end else begin
				pwr_chain[g] <= {pwr_chain[g][light_sensor_result_status_pkg::SYNC_STAGES-2:0], pwr_pins[g]};
			end
		end
		assign pwr_sync[g] = pwr_chain[g][light_sensor_result_status_pkg::SYNC_STAGES-1];
	end

	// Read only: host writes to this offset are dropped
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			power_state_flags <= light_sensor_result_status_pkg::BYTE_RST;
		end else begin
			power_state_flags                                                 <= light_sensor_result_status_pkg::BYTE_RST;
			power_state_flags[light_sensor_result_status_pkg::AWAKE_BIT]      <= pwr_sync[2];
			power_state_flags[light_sensor_result_status_pkg::WAIT_MEAS_BIT]  <= pwr_sync[1];
			power_state_flags[light_sensor_result_status_pkg::LOWEST_PWR_BIT] <= pwr_sync[0];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_int <= 1'b0;
		end else begin
			o_int <= |(i_irq_status & i_irq_enable);
		end
	end

endmodule : light_sensor_result_status_regs

// ===== light_sensor_result_status_pkg.sv
// Offsets, field positions and reset values of the result and status register group
package light_sensor_result_status_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] VISIBLE_RESULT_LOW_OFS  = 8'h22;
	localparam logic [7:0] VISIBLE_RESULT_HIGH_OFS = 8'h23;
	localparam logic [7:0] INFRARED_RESULT_LOW_OFS  = 8'h24;
	localparam logic [7:0] INFRARED_RESULT_HIGH_OFS = 8'h25;
	localparam logic [7:0] AUX_UV_RESULT_LOW_OFS   = 8'h2C;
	localparam logic [7:0] AUX_UV_RESULT_HIGH_OFS  = 8'h2D;
	localparam logic [7:0] MAILBOX_OFS             = 8'h2E;
	localparam logic [7:0] POWER_STATE_FLAGS_OFS   = 8'h30;
	localparam logic [7:0] KEY_BYTE3_OFS           = 8'h3B;
	localparam logic [7:0] KEY_BYTE2_OFS           = 8'h3C;
	localparam logic [7:0] KEY_BYTE1_OFS           = 8'h3D;
	localparam logic [7:0] KEY_BYTE0_OFS           = 8'h3E;

	// ----------------------------------------------------------------
	// Field positions of the power state flags
	// ----------------------------------------------------------------
	localparam int AWAKE_BIT      = 2;
	localparam int WAIT_MEAS_BIT  = 1;
	localparam int LOWEST_PWR_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RESULT_WORD_RST = 16'h0000;
	localparam logic [7:0]  BYTE_RST        = 8'h00;
	localparam logic [31:0] KEY_WORD_RST    = 32'h0000_0000;
	localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

	// ----------------------------------------------------------------
	// Synchroniser depth
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 2;

endpackage : light_sensor_result_status_pkg

// ===== light_sensor_result_status_asserts.sv
// Concurrent checks for the result and status register group
`timescale 1ns/1ns
module light_sensor_result_status_asserts #(
	parameter int IRQ_BITS = 8 // Interrupt vector width
) (
	input wire logic                i_mclk,              // Core clock
	input wire logic                i_srst,              // Core reset
	input wire logic                i_mailbox_we,        // Mailbox load
	input wire logic [7:0]          i_mailbox_data,      // Mailbox byte
	input wire logic [IRQ_BITS-1:0] i_irq_status,        // Status bits
	input wire logic [IRQ_BITS-1:0] i_irq_enable,        // Enable bits
	input wire logic                o_int,               // Interrupt
	input wire logic [31:0]         o_reserved_key_word, // Key field
	input wire logic [7:0]          o_mailbox,           // Mailbox
	input wire logic                i_link_clk,          // Link clock
	input wire logic                i_link_srst,         // Link reset
	input wire logic                i_link_req,          // Request
	input wire logic                i_link_we,           // Write select
	input wire logic [7:0]          i_link_addr,         // Offset
	input wire logic                o_link_busy,         // Busy
	input wire logic                o_link_ack,          // Done
	input wire logic [7:0]          o_link_rdata         // Read byte
);
	logic [7:0] taken_addr;
	logic       taken_we;
	// Remembers what the access in flight asked for
	always_ff @(posedge i_link_clk) begin
		if (i_link_req && !o_link_busy) begin
			taken_addr <= i_link_addr;
			taken_we   <= i_link_we;
		end
	end
	sequence s_take;
		i_link_req && !o_link_busy;
	endsequence
	sequence s_answer;
		o_link_busy ##[2:5] (o_link_ack && !o_link_busy);
	endsequence
	a_int_set: assert property (@(posedge i_mclk) disable iff (i_srst)
		|(i_irq_status & i_irq_enable) |=> o_int) else $error("interrupt not raised");
	a_int_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
		!(|(i_irq_status & i_irq_enable)) |=> !o_int) else $error("interrupt not dropped");
	a_mbox_load: assert property (@(posedge i_mclk) disable iff (i_srst)
		i_mailbox_we |=> o_mailbox == $past(i_mailbox_data)) else $error("mailbox not loaded");
	a_reset_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
		$fell(i_srst) |-> !o_int && o_mailbox == 8'h00 && o_reserved_key_word == 32'h0000_0000)
		else $error("register not clear after reset");
	a_ack_window: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		s_take |=> s_answer) else $error("access not answered in time");
	a_ack_pulse: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		o_link_ack |=> !o_link_ack) else $error("ack longer than one cycle");
	a_busy_holds: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		o_link_busy |=> o_link_busy || o_link_ack) else $error("busy dropped without ack");
	a_rdata_hold: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		!o_link_ack |-> $stable(o_link_rdata)) else $error("read byte changed without ack");
	a_key_stable: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		!o_link_busy && !i_link_req |=> $stable(o_reserved_key_word)) else $error("key changed while idle");
	a_flags_reserved: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		o_link_ack && !taken_we && taken_addr == 8'h30 |-> o_link_rdata[7:3] == 5'h00)
		else $error("reserved state bits set");
	a_key_msb: assert property (@(posedge i_link_clk) disable iff (i_link_srst)
		o_link_ack && !taken_we && taken_addr == 8'h3B |-> o_link_rdata == o_reserved_key_word[31:24])
		else $error("key top byte misplaced");
endmodule : light_sensor_result_status_asserts

bind light_sensor_result_status_regs light_sensor_result_status_asserts #(.IRQ_BITS(IRQ_BITS)) u_chk (
	.i_mclk, .i_srst, .i_mailbox_we, .i_mailbox_data, .i_irq_status, .i_irq_enable, .o_int,
	.o_reserved_key_word, .o_mailbox, .i_link_clk, .i_link_srst, .i_link_req, .i_link_we,
	.i_link_addr, .o_link_busy, .o_link_ack, .o_link_rdata);

// ===== link_host_model.sv
// Host model issuing byte accesses on the link register port
`timescale 1ns/1ns
module link_host_model (
	input  wire logic       i_link_clk,   // Link clock
	input  wire logic       i_link_busy,  // Access in flight
	input  wire logic       i_link_ack,   // Access done
	input  wire logic [7:0] i_link_rdata, // Read byte
	output logic            o_link_req,   // Request pulse
	output logic            o_link_we,    // Write select
	output logic [7:0]      o_link_addr,  // Offset
	output logic [7:0]      o_link_wdata  // Write byte
);
	initial begin
		o_link_req = 1'b0;
		o_link_we = 1'b0;
		o_link_addr = 8'h00;
		o_link_wdata = 8'h00;
	end
	// Lines are inverted after ack so a stale value can never pass for a held one
	task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge i_link_clk);
		o_link_req <= 1'b1;
		o_link_we <= we;
		o_link_addr <= addr;
		o_link_wdata <= wd;
		// Request stands until an edge sees the port idle
		do begin
			@(posedge i_link_clk);
			n++;
		end while (i_link_busy !== 1'b0 && n < 16);
		o_link_req <= 1'b0;
		// Answer is taken at the rising edge that sees ack high
		do begin
			@(posedge i_link_clk);
			n++;
		end while (i_link_ack !== 1'b1 && n < 32);
		rd = (i_link_ack === 1'b1) ? i_link_rdata : 8'hXX;
		o_link_we <= ~we;
		o_link_addr <= ~addr;
		o_link_wdata <= ~wd;
	endtask : access
endmodule : link_host_model

// ===== tb.sv
// Self-checking bench for the result and status register group
`timescale 1ns/1ns
module tb;
	typedef struct {logic [15:0] vis; logic [15:0] ir; logic [15:0] aux; logic [15:0] uv; logic uv_on;} row_s;
	localparam int LIMIT = 20000;
	localparam logic [31:0] KEY = 32'h8001_7F10;
	logic i_mclk = 1'b0, i_srst = 1'b1, i_link_clk = 1'b0, i_link_srst = 1'b1;
	logic i_meas_done = 1'b0, i_vis_valid = 1'b0, i_ir_valid = 1'b0, i_aux_valid = 1'b0;
	logic [15:0] i_visible_word = 16'h0000, i_infrared_word = 16'h0000;
	logic [15:0] i_aux_word = 16'h0000, i_ultraviolet_word = 16'h0000, exp_aux;
	logic i_ultraviolet_channel_on = 1'b0, i_mailbox_we = 1'b0;
	logic i_awake = 1'b0, i_wait_meas = 1'b0, i_lowest_power = 1'b0;
	logic [7:0] i_mailbox_data = 8'h00, i_irq_status = 8'h00, i_irq_enable = 8'h00;
	logic o_int, o_link_busy, o_link_ack, i_link_req, i_link_we;
	logic [31:0] o_reserved_key_word;
	logic [7:0] o_mailbox, o_link_rdata, i_link_addr, i_link_wdata;
	int fails = 0, comparisons = 0, cycles = 0;
	row_s rows [3] = '{'{16'h1234, 16'hABCD, 16'h00FF, 16'h0007, 1'b0},
		'{16'hFFFF, 16'h0001, 16'h8000, 16'h0B0E, 1'b1}, '{16'h0000, 16'hFFFF, 16'h5A5A, 16'h0102, 1'b0}};
	logic [7:0] ofs [12] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h2C, 8'h2D, 8'h2E, 8'h30, 8'h3B, 8'h3C, 8'h3D, 8'h3E};
	// Expected interrupt level, status, enable
	logic [16:0] irq [4] = '{17'h0_1001, 17'h1_1010, 17'h1_FF80, 17'h0_00FF};
	initial begin
		forever #2 i_mclk = ~i_mclk;
	end
	initial begin
		#5;
		forever #32 i_link_clk = ~i_link_clk;
	end
	light_sensor_result_status_regs #(.IRQ_BITS(8)) DUT (.i_mclk, .i_srst, .i_meas_done, .i_vis_valid,
		.i_visible_word, .i_ir_valid, .i_infrared_word, .i_aux_valid, .i_aux_word, .i_ultraviolet_channel_on,
		.i_ultraviolet_word, .i_mailbox_we, .i_mailbox_data, .i_awake, .i_wait_meas, .i_lowest_power,
		.i_irq_status, .i_irq_enable, .o_int, .o_reserved_key_word, .o_mailbox, .i_link_clk, .i_link_srst,
		.i_link_req, .i_link_we, .i_link_addr, .i_link_wdata, .o_link_busy, .o_link_ack, .o_link_rdata);
	link_host_model host (.i_link_clk, .i_link_busy(o_link_busy), .i_link_ack(o_link_ack),
		.i_link_rdata(o_link_rdata), .o_link_req(i_link_req), .o_link_we(i_link_we),
		.o_link_addr(i_link_addr), .o_link_wdata(i_link_wdata));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.access(1'b0, a, 8'h00, v);
		check($sformatf("read %h", a), {24'h000000, v}, {24'h000000, exp});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		host.access(1'b1, a, d, v);
		check($sformatf("write %h", a), {24'h000000, v}, 32'h0000_0000);
	endtask : wr
	task automatic final_report();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_srst <= 1'b0;
		repeat (4) @(posedge i_link_clk);
		i_link_srst <= 1'b0;
		check("key", o_reserved_key_word, 32'h0000_0000);
		check("mailbox", {24'h000000, o_mailbox}, 32'h0000_0000);
		foreach (ofs[k]) rd(ofs[k], 8'h00);
		// Each result is read before the next measurement lands
		foreach (rows[k]) begin
			@(posedge i_mclk);
			{i_vis_valid, i_ir_valid, i_aux_valid, i_meas_done} <= 4'hF;
			i_visible_word <= rows[k].vis;
			i_infrared_word <= rows[k].ir;
			i_aux_word <= rows[k].aux;
			i_ultraviolet_word <= rows[k].uv;
			i_ultraviolet_channel_on <= rows[k].uv_on;
			@(posedge i_mclk);
			i_meas_done <= 1'b0;
			exp_aux = rows[k].uv_on ? rows[k].uv : rows[k].aux;
			rd(8'h22, rows[k].vis[7:0]);
			rd(8'h23, rows[k].vis[15:8]);
			rd(8'h24, rows[k].ir[7:0]);
			rd(8'h25, rows[k].ir[15:8]);
			rd(8'h2C, exp_aux[7:0]);
			rd(8'h2D, exp_aux[15:8]);
		end
		// Only the qualified word may load
		@(posedge i_mclk);
		{i_vis_valid, i_ir_valid, i_aux_valid, i_meas_done} <= 4'h5;
		i_visible_word <= 16'hBEEF;
		i_infrared_word <= 16'h0F0F;
		@(posedge i_mclk);
		i_meas_done <= 1'b0;
		rd(8'h23, 8'h00);
		rd(8'h25, 8'h0F);
		@(posedge i_mclk);
		i_mailbox_we <= 1'b1;
		i_mailbox_data <= 8'hA5;
		@(posedge i_mclk);
		i_mailbox_we <= 1'b0;
		rd(8'h2E, 8'hA5);
		check("mailbox", {24'h000000, o_mailbox}, 32'h0000_00A5);
		for (int k = 0; k < 3; k++) begin
			@(posedge i_mclk);
			{i_awake, i_wait_meas, i_lowest_power} <= 3'h4 >> k;
			repeat (6) @(posedge i_mclk);
			rd(8'h30, 8'h04 >> k);
		end
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h01);
		rd(8'h31, 8'h00);
		for (int k = 0; k < 4; k++) wr(8'(8'h3B + k), KEY[31 - 8 * k -: 8]);
		check("key", o_reserved_key_word, KEY);
		for (int k = 0; k < 4; k++) rd(8'(8'h3B + k), KEY[31 - 8 * k -: 8]);
		foreach (irq[k]) begin
			@(posedge i_mclk);
			i_irq_status <= irq[k][15:8];
			i_irq_enable <= irq[k][7:0];
			repeat (2) @(posedge i_mclk);
			check("int", {31'h00000000, o_int}, {31'h00000000, irq[k][16]});
		end
		// Mid-run reset: link side first so no access is cut, core released first
		@(posedge i_link_clk);
		i_link_srst <= 1'b1;
		@(posedge i_mclk);
		i_srst <= 1'b1;
		repeat (20) @(posedge i_mclk);
		i_srst <= 1'b0;
		repeat (4) @(posedge i_link_clk);
		i_link_srst <= 1'b0;
		check("key", o_reserved_key_word, 32'h0000_0000);
		check("mailbox", {24'h000000, o_mailbox}, 32'h0000_0000);
		rd(8'h3B, 8'h00);
		rd(8'h25, 8'h00);
		final_report();
	end
endmodule : tb
